// file: logic/reply_coord_pkg.sv
package reply_coord_pkg;

	// ----------------------------------------
	// interrogation kinds from the front end
	// ----------------------------------------
	typedef enum logic [2:0] {
		INT_MODE_A = 3'h0,
		INT_MODE_C = 3'h1,
		INT_ALLCALL_A = 3'h2,
		INT_ALLCALL_C = 3'h3,
		INT_MODE_S = 3'h4
	} interrog_e;

	// ----------------------------------------
	// reply selection
	// ----------------------------------------
	typedef enum logic [2:0] {
		REPLY_NONE = 3'h0,
		REPLY_ALTITUDE = 3'h1,
		REPLY_IDENTITY = 3'h2,
		REPLY_ALLCALL = 3'h3,
		REPLY_SURV_COMMB = 3'h4
	} reply_e;

	// ----------------------------------------
	// field widths and codes
	// ----------------------------------------
	localparam int UF_W = 5;
	localparam int ALT_W = 13;
	localparam int ID_W = 13;
	localparam int CA_W = 3;

	localparam logic [UF_W-1:0] UF_SURV_ALT = 5'h04;
	localparam logic [UF_W-1:0] UF_SURV_ID = 5'h05;
	localparam logic [UF_W-1:0] UF_ALLCALL = 5'h0B;
	localparam logic [UF_W-1:0] UF_AIR_COORD = 5'h10;
	localparam logic [UF_W-1:0] UF_COMMB_ALT = 5'h14;
	localparam logic [UF_W-1:0] UF_COMMB_ID = 5'h15;

	localparam logic [UF_W-1:0] DF_AIR_COORD = 5'h10;
	localparam logic [UF_W-1:0] DF_ALLCALL = 5'h0B;
	localparam logic [UF_W-1:0] DF_EXT_SQUITTER = 5'h11;

	localparam logic [CA_W-1:0] CA_MIN_REPORT = 3'h4;
	localparam logic [CA_W-1:0] CA_MAX_REPORT = 3'h7;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int MODE_A_SPACING_NS = 8000;
	localparam int MODE_A_SPACING_CYC = (MODE_A_SPACING_NS * (CLK_HZ / 1_000_000)) / 1000;
	// recovery dead time after a rejected mode A, treated like a desensitising pulse
	localparam int RECOVER_NS = 15000;
	localparam int RECOVER_CYC_RAW = (RECOVER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int RECOVER_CYC = (RECOVER_CYC_RAW < 1) ? 1 : RECOVER_CYC_RAW;
	localparam int RECOVER_W = 10;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		interrog_e kind;
		logic [UF_W-1:0] uf;
	} interrog_s;

	typedef struct packed {
		reply_e kind;
		logic [UF_W-1:0] df;
		logic [CA_W-1:0] ca;
		logic [ALT_W-1:0] alt;
	} reply_s;

endpackage : reply_coord_pkg

// file: logic/pin_sync.sv
module pin_sync (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_async,
	output logic o_sync
);
	logic stage1;

	// ----------------------------------------
	// two-stage synchroniser
	// ----------------------------------------
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			stage1 <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule : pin_sync

// file: logic/recovery_timer.sv
module recovery_timer
	import reply_coord_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_start,
	output logic o_busy
);
	logic [RECOVER_W-1:0] count;
	wire logic [RECOVER_W-1:0] next_count;

	// ----------------------------------------
	// dead time counter
	// ----------------------------------------
	assign next_count = i_start ? RECOVER_W'(RECOVER_CYC) :
		(count != '0) ? count - RECOVER_W'(1) : count;
	assign o_busy = (count != '0);

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule : recovery_timer

// file: logic/mode_s_reply_coordinator.sv
// Function
// - a valid mode A interrogation yields no reply unless the build is full level 2
// - a valid mode C interrogation yields an altitude code reply while not on ground
// - no reply to any all-call and no DF 11 unless the build is full level 2
// - uplink format 16 is rejected, never accepted
// - UF/DF 20 and 21 are processed; DF 16 is never produced
// - capability field can report codes 4 through 7
// - ground-initiated Comm-B kept; air-initiated and broadcast Comm-B left out
// - full level 2 build keeps original replies incl. identity and all-call
// - never claim elementary surveillance compliance
// - surveillance register changes raise no Comm-B broadcast
// - never claim enhanced surveillance compliance
// - no lockout or UM protocol; acceptance never blocked by lockout
// - no Comm-A reception or linked Comm-A
// - no extended Comm-U/V, multisite or sensor broadcast reception
// - no automatic data link capability update
// - no aircraft identification change signalling
// - surveillance identifier codes are not handled
// - no all-call reply protocol
// - position broadcast goes out as 1090 MHz extended squitter
// - mode A by P1-P3 8 us spacing rejected, then desensitise recovery
module mode_s_reply_coordinator
	import reply_coord_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_full_level2,
	input wire logic i_on_ground,
	input wire logic i_p1_pulse,
	input wire logic i_p3_pulse,
	input wire logic i_int_valid,
	input reply_coord_pkg::interrog_s i_int,
	input wire logic [ALT_W-1:0] i_alt_code,
	input wire logic [CA_W-1:0] i_ca_code,
	input wire logic i_squitter_req,
	output reply_coord_pkg::reply_s o_reply,
	output logic o_reply_valid,
	output logic o_reject,
	output logic o_recovering,
	output logic o_squitter_go,
	output logic [UF_W-1:0] o_squitter_df,
	output logic o_els_claim,
	output logic o_ehs_claim,
	output logic o_commb_bcast
);
	import reply_coord_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DECIDE = 3'b010,
		ST_ISSUE = 3'b100
	} coord_e;

	coord_e state;
	coord_e next_state;
	interrog_s held;
	logic [ALT_W-1:0] alt_held;
	logic [7:0] spacing;
	logic spacing_run;
	logic p1_q;
	logic p3_q;
	logic p1_prev;
	logic p3_prev;
	logic mode_a_seen;
	wire logic p1_rise;
	wire logic p3_rise;
	wire logic is_mode_a_spacing;
	wire logic recover_busy;
	wire logic accept;
	wire logic uf_known;
	wire logic int_surv;
	wire logic int_commb;
	wire logic int_allcall;
	wire logic int_air_coord;
	wire logic spacing_max;
	wire logic [CA_W-1:0] ca_sel;
	reply_s next_reply;
	wire logic next_reject;

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	function automatic logic rising(input logic cur, input logic prev);
		rising = cur & ~prev;
	endfunction : rising

	function automatic logic uf_is_surv(input logic [UF_W-1:0] uf);
		uf_is_surv = (uf == UF_SURV_ALT) | (uf == UF_SURV_ID);
	endfunction : uf_is_surv

	function automatic logic uf_is_commb(input logic [UF_W-1:0] uf);
		uf_is_commb = (uf == UF_COMMB_ALT) | (uf == UF_COMMB_ID);
	endfunction : uf_is_commb

	function automatic logic uf_is_allcall(input logic [UF_W-1:0] uf);
		uf_is_allcall = (uf == UF_ALLCALL);
	endfunction : uf_is_allcall

	function automatic logic uf_is_air_coord(input logic [UF_W-1:0] uf);
		uf_is_air_coord = (uf == UF_AIR_COORD);
	endfunction : uf_is_air_coord

	// all-call answers exist only in a full level 2 build
	function automatic reply_e allcall_kind(input logic level2);
		allcall_kind = level2 ? REPLY_ALLCALL : REPLY_NONE;
	endfunction : allcall_kind

	function automatic logic [UF_W-1:0] allcall_df(input logic level2);
		allcall_df = level2 ? DF_ALLCALL : '0;
	endfunction : allcall_df

	// ----------------------------------------
	// pulse inputs from the receiver
	// ----------------------------------------
	pin_sync u_p1_sync (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_async(i_p1_pulse),
		.o_sync(p1_q)
	);

	pin_sync u_p3_sync (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_async(i_p3_pulse),
		.o_sync(p3_q)
	);

	assign p1_rise = rising(p1_q, p1_prev);
	assign p3_rise = rising(p3_q, p3_prev);
	assign is_mode_a_spacing = p3_rise & spacing_run &
		(spacing == 8'(MODE_A_SPACING_CYC - 1));

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			p1_prev <= 1'b0;
			p3_prev <= 1'b0;
		end else begin
			p1_prev <= p1_q;
			p3_prev <= p3_q;
		end
	end

	// ----------------------------------------
	// p1 to p3 spacing count
	// ----------------------------------------
	assign spacing_max = (spacing == 8'hFF);

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			spacing <= 8'h00;
			spacing_run <= 1'b0;
		end else begin
			if (p1_rise) begin
				spacing <= 8'h00;
				spacing_run <= 1'b1;
			end else if (p3_rise || spacing_max) begin
				spacing_run <= 1'b0;
			end else if (spacing_run) begin
				spacing <= spacing + 8'h01;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			mode_a_seen <= 1'b0;
		end else begin
			mode_a_seen <= is_mode_a_spacing;
		end
	end

	// ----------------------------------------
	// recovery after a rejected mode A
	// ----------------------------------------
	recovery_timer u_recover (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_start(is_mode_a_spacing),
		.o_busy(recover_busy)
	);

	// ----------------------------------------
	// recovery status
	// ----------------------------------------
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_recovering <= 1'b0;
		end else begin
			o_recovering <= recover_busy;
		end
	end

	// ----------------------------------------
	// acceptance
	// ----------------------------------------
	// lockout has no part in acceptance
	assign accept = i_int_valid & ~recover_busy & (state == ST_IDLE);
	assign int_surv = uf_is_surv(i_int.uf);
	assign int_commb = uf_is_commb(i_int.uf);
	assign int_allcall = uf_is_allcall(i_int.uf);
	assign int_air_coord = uf_is_air_coord(i_int.uf);
	assign uf_known = int_surv | int_commb | int_allcall | int_air_coord;

	// ----------------------------------------
	// capability field
	// ----------------------------------------
	assign ca_sel = (i_ca_code < CA_MIN_REPORT) ? CA_MIN_REPORT : i_ca_code;

	// ----------------------------------------
	// reply decision
	// ----------------------------------------
	always_comb begin
		next_reply = '0;
		next_reply.kind = REPLY_NONE;
		next_reply.ca = ca_sel;
		next_reply.alt = alt_held;
		unique case (held.kind)
			INT_MODE_A: begin
				// identity reply only for a full level 2 build
				next_reply.kind = i_full_level2 ? REPLY_IDENTITY : REPLY_NONE;
			end
			INT_MODE_C: begin
				next_reply.kind = REPLY_ALTITUDE;
			end
			INT_ALLCALL_A, INT_ALLCALL_C: begin
				next_reply.kind = allcall_kind(i_full_level2);
				next_reply.df = allcall_df(i_full_level2);
			end
			INT_MODE_S: begin
				unique case (held.uf)
					UF_SURV_ALT, UF_SURV_ID: begin
						next_reply.kind = REPLY_SURV_COMMB;
						next_reply.df = held.uf;
					end
					UF_COMMB_ALT, UF_COMMB_ID: begin
						// ground-initiated Comm-B only
						next_reply.kind = REPLY_SURV_COMMB;
						next_reply.df = held.uf;
					end
					UF_ALLCALL: begin
						next_reply.kind = allcall_kind(i_full_level2);
						next_reply.df = allcall_df(i_full_level2);
					end
					default: begin
						// rejected UF 16 and unknown formats land here but never reach ST_DECIDE
						next_reply.kind = REPLY_NONE;
					end
				endcase
			end
			default: begin
				next_reply.kind = REPLY_NONE;
			end
		endcase
		if (i_on_ground) begin
			next_reply.kind = REPLY_NONE;
		end
		if (next_reply.kind == REPLY_NONE) begin
			next_reply.df = '0;
		end
	end

	// UF 16 and formats outside the set are rejected; no Comm-A/U/V, SI or broadcast path
	assign next_reject = accept & (i_int.kind == INT_MODE_S) &
		(int_air_coord | ~uf_known);

	// ----------------------------------------
	// decision sequence
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (accept && !next_reject) begin
					next_state = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				next_state = ST_ISSUE;
			end
			ST_ISSUE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state <= ST_IDLE;
			held <= '0;
			alt_held <= '0;
		end else begin
			state <= next_state;
			if (accept) begin
				held <= i_int;
				alt_held <= i_alt_code;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_reject <= 1'b0;
		end else begin
			o_reject <= next_reject | mode_a_seen;
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_reply <= '0;
			o_reply_valid <= 1'b0;
		end else begin
			o_reply_valid <= 1'b0;
			if (state == ST_DECIDE) begin
				o_reply <= next_reply;
				o_reply_valid <= (next_reply.kind != REPLY_NONE);
			end
		end
	end

	// ----------------------------------------
	// squitter and capability reporting
	// ----------------------------------------
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_squitter_go <= 1'b0;
			o_squitter_df <= '0;
		end else begin
			o_squitter_go <= i_squitter_req;
			o_squitter_df <= DF_EXT_SQUITTER;
		end
	end

	assign o_els_claim = 1'b0;
	assign o_ehs_claim = 1'b0;
	// no broadcast on register change or capability change
	assign o_commb_bcast = 1'b0;

endmodule : mode_s_reply_coordinator

// file: tb/coordinator_monitor.sv
module coordinator_monitor
	import reply_coord_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_full_level2,
	input wire logic i_int_valid,
	input reply_coord_pkg::interrog_s i_int,
	input wire logic [ALT_W-1:0] i_alt_code,
	input wire logic i_squitter_req,
	input reply_coord_pkg::reply_s o_reply,
	input wire logic o_reply_valid,
	input wire logic o_squitter_go,
	input wire logic [UF_W-1:0] o_squitter_df,
	input wire logic o_els_claim,
	input wire logic o_ehs_claim,
	input wire logic o_commb_bcast
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------
	// checks
	// ----------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	wire is_s = i_int_valid && i_int.kind == INT_MODE_S;
	mode_a_silent_a: assert property (i_int_valid && i_int.kind == INT_MODE_A
		&& !i_full_level2 |-> ##2 !o_reply_valid) else $error("mode a reply");
	mode_c_alt_a: assert property (i_int_valid && i_int.kind == INT_MODE_C |-> ##2
		(!o_reply_valid || o_reply.kind == REPLY_ALTITUDE && o_reply.alt == $past(i_alt_code, 2)))
		else $error("mode c reply wrong");
	allcall_silent_a: assert property (!i_full_level2 && (is_s && i_int.uf == UF_ALLCALL
		|| i_int_valid && i_int.kind inside {INT_ALLCALL_A, INT_ALLCALL_C}) |-> ##2
		!o_reply_valid) else $error("all-call reply");
	uf16_refused_a: assert property (is_s && i_int.uf == UF_AIR_COORD
		|-> ##2 !o_reply_valid) else $error("uf 16 reply");
	surv_df_a: assert property (is_s && i_int.uf inside {5'h04, 5'h05, 5'h14, 5'h15}
		|-> ##2 (!o_reply_valid || o_reply.df == $past(i_int.uf, 2))) else $error("df wrong");
	ca_range_a: assert property (o_reply_valid |-> o_reply.ca >= CA_MIN_REPORT)
		else $error("ca low");
	one_pulse_a: assert property (o_reply_valid |-> o_reply.kind != REPLY_NONE
		##1 !o_reply_valid) else $error("reply pulse wrong");
	no_claims_a: assert property (!o_els_claim && !o_ehs_claim)
		else $error("compliance claimed");
	no_bcast_a: assert property (!o_commb_bcast) else $error("broadcast raised");
	squitter_a: assert property (!$past(i_reset) |-> o_squitter_df == DF_EXT_SQUITTER
		&& o_squitter_go == $past(i_squitter_req)) else $error("squitter wrong");
	cover property (o_reply_valid && o_reply.kind == REPLY_ALTITUDE);
	cover property (o_reply_valid && o_reply.kind == REPLY_SURV_COMMB);
	cover property (o_squitter_go);
endmodule : coordinator_monitor

// file: tb/interrogator_model.sv
module interrogator_model
	import reply_coord_pkg::*;
(
	input wire logic i_mclk,
	output logic o_valid,
	output reply_coord_pkg::interrog_s o_int,
	output logic o_p1,
	output logic o_p3,
	output logic [ALT_W-1:0] o_alt
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------
	// far side
	// ----------
	initial begin
		o_valid = 1'b0;
		o_int = '0;
		o_p1 = 1'b0;
		o_p3 = 1'b0;
		o_alt = '0;
	end
	task automatic send(input interrog_e k, input logic [UF_W-1:0] uf, input logic [ALT_W-1:0] a);
		@(negedge i_mclk);
		o_int = '{kind: k, uf: uf};
		o_alt = a;
		o_valid = 1'b1;
		@(negedge i_mclk);
		o_valid = 1'b0;
		o_int = ~o_int;
		o_alt = ~o_alt;
	endtask : send
	task automatic pulses(input int gap);
		@(negedge i_mclk);
		o_p1 = 1'b1;
		repeat (4) @(negedge i_mclk);
		o_p1 = 1'b0;
		repeat (gap - 4) @(negedge i_mclk);
		o_p3 = 1'b1;
		repeat (4) @(negedge i_mclk);
		o_p3 = 1'b0;
	endtask : pulses
endmodule : interrogator_model

// file: tb/test_mode_s_reply_coordinator.sv
`define chk(n, e, a) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
	$display("unexpected %s expected %0h seen %0h", n, e, a); end end
module test_mode_s_reply_coordinator;
	timeunit 1ns;
	timeprecision 1ns;
	import reply_coord_pkg::*;
	// ----------
	// bench
	// ----------
	logic mclk = 0, reset = 1, level2 = 0, ground = 0, sq_req = 0;
	logic [CA_W-1:0] ca_code = 3'h0;
	logic int_valid, p1, p3, reply_valid, reject, recovering, sq_go, els, ehs, bcast;
	interrog_s int_word;
	logic [ALT_W-1:0] alt;
	reply_s reply;
	logic [UF_W-1:0] sq_df;
	int num_errors = 0;
	int comparisons = 0;
	initial forever #20 mclk = ~mclk;
	interrogator_model far (.i_mclk(mclk), .o_valid(int_valid), .o_int(int_word), .o_p1(p1),
		.o_p3(p3), .o_alt(alt));
	mode_s_reply_coordinator dut (.i_mclk(mclk), .i_reset(reset), .i_full_level2(level2),
		.i_on_ground(ground), .i_p1_pulse(p1), .i_p3_pulse(p3), .i_int_valid(int_valid),
		.i_int(int_word), .i_alt_code(alt), .i_ca_code(ca_code), .i_squitter_req(sq_req),
		.o_reply(reply), .o_reply_valid(reply_valid), .o_reject(reject),
		.o_recovering(recovering),
		.o_squitter_go(sq_go), .o_squitter_df(sq_df), .o_els_claim(els), .o_ehs_claim(ehs),
		.o_commb_bcast(bcast));
	task automatic ask(input interrog_e k, input logic [UF_W-1:0] uf,
			input logic [ALT_W-1:0] a, input logic erej, input reply_e ek);
		far.send(k, uf, a);
		`chk("reject", erej, reject)
		@(negedge mclk);
		`chk("valid", ek != REPLY_NONE, reply_valid)
		if (ek != REPLY_NONE) `chk("kind", ek, reply.kind)
	endtask : ask
	task automatic t_modes;
		logic [UF_W-1:0] ufs [4] = '{UF_SURV_ALT, UF_SURV_ID, UF_COMMB_ALT, UF_COMMB_ID};
		ask(INT_MODE_A, 5'h00, 13'h0000, 1'b0, REPLY_NONE);
		ask(INT_MODE_C, 5'h00, 13'h1A5C, 1'b0, REPLY_ALTITUDE);
		`chk("alt", 13'h1A5C, reply.alt)
		ask(INT_ALLCALL_A, 5'h00, 13'h0000, 1'b0, REPLY_NONE);
		ask(INT_ALLCALL_C, 5'h00, 13'h0000, 1'b0, REPLY_NONE);
		ask(INT_MODE_S, UF_ALLCALL, 13'h0000, 1'b0, REPLY_NONE);
		ask(INT_MODE_S, UF_AIR_COORD, 13'h0000, 1'b1, REPLY_NONE);
		ask(INT_MODE_S, 5'h18, 13'h0000, 1'b1, REPLY_NONE);
		foreach (ufs[i]) begin
			ask(INT_MODE_S, ufs[i], 13'h0000, 1'b0, REPLY_SURV_COMMB);
			`chk("df", ufs[i], reply.df)
		end
	endtask : t_modes
	task automatic t_level2;
		level2 = 1'b1;
		ask(INT_MODE_A, 5'h00, 13'h0000, 1'b0, REPLY_IDENTITY);
		ask(INT_MODE_S, UF_ALLCALL, 13'h0000, 1'b0, REPLY_ALLCALL);
		`chk("df", DF_ALLCALL, reply.df)
		level2 = 1'b0;
	endtask : t_level2
	task automatic t_ca;
		for (int c = 0; c < 8; c++) begin
			ca_code = 3'(c);
			ask(INT_MODE_C, 5'h00, 13'h0001, 1'b0, REPLY_ALTITUDE);
			`chk("ca", (c < 4) ? CA_MIN_REPORT : 3'(c), reply.ca)
		end
	endtask : t_ca
	task automatic t_ground;
		ground = 1'b1;
		ask(INT_MODE_C, 5'h00, 13'h0004, 1'b0, REPLY_NONE);
		ground = 1'b0;
	endtask : t_ground
	task automatic t_spacing;
		logic seen;
		for (int g = 150; g <= 200; g += 50) begin
			seen = 1'b0;
			fork
				far.pulses(g);
				repeat (230) begin
					@(negedge mclk);
					seen |= reject;
				end
			join
			`chk("spacing", g == 200, seen)
		end
		`chk("recovering", 1'b1, recovering)
		ask(INT_MODE_C, 5'h00, 13'h0002, 1'b0, REPLY_NONE);
		repeat (RECOVER_CYC) @(negedge mclk);
		`chk("recovering", 1'b0, recovering)
		ask(INT_MODE_C, 5'h00, 13'h0003, 1'b0, REPLY_ALTITUDE);
	endtask : t_spacing
	task automatic t_squitter;
		sq_req = 1'b1;
		@(negedge mclk);
		sq_req = 1'b0;
		`chk("go", 1'b1, sq_go)
		`chk("df", DF_EXT_SQUITTER, sq_df)
		`chk("claims", 3'h0, {els, ehs, bcast})
		@(negedge mclk);
		`chk("go", 1'b0, sq_go)
	endtask : t_squitter
	task automatic finish_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (8) @(negedge mclk);
		reset = 1'b0;
		t_modes();
		t_level2();
		t_ca();
		t_ground();
		t_spacing();
		t_squitter();
		finish_test();
	end
endmodule : test_mode_s_reply_coordinator
bind mode_s_reply_coordinator coordinator_monitor mon (.i_mclk, .i_reset, .i_full_level2,
	.i_int_valid, .i_int, .i_alt_code, .i_squitter_req, .o_reply, .o_reply_valid,
	.o_squitter_go, .o_squitter_df, .o_els_claim, .o_ehs_claim, .o_commb_bcast);
